// file: src/dpsr_defines.vh
// Purpose: Constants for the dual-port synchronous RAM.
// Assumes: Included by every design file of the RAM.
// Notes:   Geometry is fixed; it must respect the generator limits below.
`ifndef DPSR_DEFINES_VH
`define DPSR_DEFINES_VH

// Chosen geometry: words, bits per word, column multiplexing
`define DPSR_WORDS       256
`define DPSR_BITS        16
`define DPSR_ADDR_W      8
`define DPSR_YMUX        4

// Generator limits
`define DPSR_MAX_WORDS   8192
`define DPSR_MAX_BITS    128
`define DPSR_MAX_TOTAL   65536
`define DPSR_MIN_YMUX    2
`define DPSR_MAX_YMUX    32
`define DPSR_MIN_STEPS   2
`define DPSR_MAX_STEPS   256

// Synchroniser depth for pin inputs
`define DPSR_SYNC_STAGES 2

// Reset value of the read-word registers
`define DPSR_WORD_RESET  16'h0000

`endif

// file: src/dpsr_port_sync.v
// Purpose: Brings one RAM port's pins into the I_CLK domain.
// Assumes: Pins stay stable while the port clock is high.
// Notes:   All pins share the same two-stage delay so they stay aligned.
`timescale 1ns/1ps
`include "dpsr_defines.vh"

module dpsr_port_sync (
   // System
   input  wire                      i_clk,
   input  wire                      i_reset,
   input  wire                      i_ce,
   // Port pins
   input  wire                      i_port_clock,
   input  wire                      i_select_n,
   input  wire                      i_write_n,
   input  wire                      i_drive_n,
   input  wire [`DPSR_ADDR_W-1:0]   i_location,
   input  wire [`DPSR_BITS-1:0]     i_write_word,
   // Decoded port state
   output wire                      o_access,
   output wire                      o_write,
   output wire                      o_drive,
   output wire [`DPSR_ADDR_W-1:0]   o_location,
   output wire [`DPSR_BITS-1:0]     o_word
);

   localparam PW = 4 + `DPSR_ADDR_W + `DPSR_BITS;

   reg  [PW-1:0]  meta_reg;
   reg  [PW-1:0]  sync_reg;
   reg            clk_prev_reg;
   wire [PW-1:0]  pins;
   wire           clk_s;
   wire           sel_n_s;
   wire           wr_n_s;
   wire           drv_n_s;

   assign pins = {i_port_clock, i_select_n, i_write_n, i_drive_n, i_location, i_write_word};

   always @(posedge i_clk) begin
      if (i_reset) begin
         meta_reg     <= {PW{1'b0}};
         sync_reg     <= {PW{1'b0}};
         clk_prev_reg <= 1'b0;
      end else if (i_ce) begin
         meta_reg     <= pins;
         sync_reg     <= meta_reg;
         clk_prev_reg <= clk_s;
      end
   end

   assign clk_s      = sync_reg[PW-1];
   assign sel_n_s    = sync_reg[PW-2];
   assign wr_n_s     = sync_reg[PW-3];
   assign drv_n_s    = sync_reg[PW-4];
   assign o_location = sync_reg[`DPSR_ADDR_W+`DPSR_BITS-1:`DPSR_BITS];
   assign o_word     = sync_reg[`DPSR_BITS-1:0];

   // Access only at the rising port clock edge while selected
   assign o_access = clk_s & ~clk_prev_reg & ~sel_n_s; // [R03] [R04]
   assign o_write  = ~wr_n_s;
   // Driver on only while clock high, selected and enabled
   assign o_drive  = clk_s & ~sel_n_s & ~drv_n_s; // [R08]

endmodule

// file: src/dpsr_top.v
// Purpose: Dual-port synchronous static RAM, both ports sampled on I_CLK.
// Assumes: Port clocks are slow pins; each high phase spans several I_CLK cycles.
// Notes:   No contention guard; same-cycle read of a location the other port
//          writes returns an undefined word. Memory contents are not reset.
// Behaviour
// [R01] Selected rising edge with write negated reads addressed word onto read outputs.
// [R02] Selected rising edge with write asserted stores the write word at address.
// [R03] Deselected port is in stand-by and performs no access.
// [R04] Port precharges while its clock is low; access begins at rising edge.
// [R05] Driving logic keeps select stable while port clock is high.
// [R06] Driving logic keeps output enable stable while port clock is high.
// [R07] Driving logic keeps address stable while port clock is high.
// [R08] Read outputs driven only with clock high, selected and enabled.
// [R09] During a write, an enabled driver shows the word being written.
// [R10] Both ports identical and fully independent.
// [R11] Surrounding logic must avoid or tolerate same-location dual access.
// [R12] Users wanting stable read data outside clock high add bus holders.
// [R13] At most 8K words, 128 bits per word, 64K bits total.
// [R14] Column mux 2 to 32; words 2 to 256 times mux, in mux steps.
// [R15] Read of a location the other port writes that cycle returns undefined.
`timescale 1ns/1ps
`include "dpsr_defines.vh"

module dpsr_top (
   // System
   input  wire                      I_CLK,
   input  wire                      I_RESET,
   input  wire                      I_CE,
   // Port A pins
   input  wire                      I_PORT_A_CLOCK,
   input  wire                      I_PORT_A_SELECT_N,
   input  wire                      I_PORT_A_WRITE_N,
   input  wire                      I_PORT_A_DRIVE_N,
   input  wire [`DPSR_ADDR_W-1:0]   I_PORT_A_LOCATION,
   input  wire [`DPSR_BITS-1:0]     I_PORT_A_WRITE_WORD,
   // Port B pins
   input  wire                      I_PORT_B_CLOCK,
   input  wire                      I_PORT_B_SELECT_N,
   input  wire                      I_PORT_B_WRITE_N,
   input  wire                      I_PORT_B_DRIVE_N,
   input  wire [`DPSR_ADDR_W-1:0]   I_PORT_B_LOCATION,
   input  wire [`DPSR_BITS-1:0]     I_PORT_B_WRITE_WORD,
   // Read outputs with driver enables
   output wire [`DPSR_BITS-1:0]     O_PORT_A_READ_WORD,
   output wire                      O_PORT_A_READ_WORD_OE,
   output wire [`DPSR_BITS-1:0]     O_PORT_B_READ_WORD,
   output wire                      O_PORT_B_READ_WORD_OE
);

   // Geometry limits checked at elaboration time
   localparam GEOM_OK = (`DPSR_WORDS <= `DPSR_MAX_WORDS)
                      && (`DPSR_BITS <= `DPSR_MAX_BITS)
                      && (`DPSR_WORDS * `DPSR_BITS <= `DPSR_MAX_TOTAL); // [R13]
   localparam MUX_OK  = (`DPSR_YMUX >= `DPSR_MIN_YMUX) && (`DPSR_YMUX <= `DPSR_MAX_YMUX)
                      && (`DPSR_WORDS % `DPSR_YMUX == 0)
                      && (`DPSR_WORDS >= `DPSR_MIN_STEPS * `DPSR_YMUX)
                      && (`DPSR_WORDS <= `DPSR_MAX_STEPS * `DPSR_YMUX); // [R14]
   // All-ones equals the last word only because the depth is a full power of two
   localparam [`DPSR_ADDR_W-1:0] TOP_LOC = (GEOM_OK && MUX_OK) ? {`DPSR_ADDR_W{1'b1}}
                                                               : {`DPSR_ADDR_W{1'b0}};

   // Decoded port state, index 0 is port A, 1 is port B
   wire [1:0]                  acc;
   wire [1:0]                  wr;
   wire [1:0]                  drv;
   wire [`DPSR_ADDR_W-1:0]     loc    [0:1];
   wire [`DPSR_BITS-1:0]       wword  [0:1];

   reg  [`DPSR_BITS-1:0]       mem_reg  [0:`DPSR_WORDS-1];
   reg  [`DPSR_BITS-1:0]       word_reg [0:1];
   reg  [1:0]                  oe_reg;

   // True when the other port writes this port's location this cycle
   function clash;
      input                     other_acc;
      input                     other_wr;
      input [`DPSR_ADDR_W-1:0]  other_loc;
      input [`DPSR_ADDR_W-1:0]  own_loc;
      begin
         clash = other_acc & other_wr & (other_loc == own_loc);
      end
   endfunction

   dpsr_port_sync u_sync_a (
      .i_clk        (I_CLK),
      .i_reset      (I_RESET),
      .i_ce         (I_CE),
      .i_port_clock (I_PORT_A_CLOCK),
      .i_select_n   (I_PORT_A_SELECT_N),
      .i_write_n    (I_PORT_A_WRITE_N),
      .i_drive_n    (I_PORT_A_DRIVE_N),
      .i_location   (I_PORT_A_LOCATION),
      .i_write_word (I_PORT_A_WRITE_WORD),
      .o_access     (acc[0]),
      .o_write      (wr[0]),
      .o_drive      (drv[0]),
      .o_location   (loc[0]),
      .o_word       (wword[0])
   );

   dpsr_port_sync u_sync_b (
      .i_clk        (I_CLK),
      .i_reset      (I_RESET),
      .i_ce         (I_CE),
      .i_port_clock (I_PORT_B_CLOCK),
      .i_select_n   (I_PORT_B_SELECT_N),
      .i_write_n    (I_PORT_B_WRITE_N),
      .i_drive_n    (I_PORT_B_DRIVE_N),
      .i_location   (I_PORT_B_LOCATION),
      .i_write_word (I_PORT_B_WRITE_WORD),
      .o_access     (acc[1]),
      .o_write      (wr[1]),
      .o_drive      (drv[1]),
      .o_location   (loc[1]),
      .o_word       (wword[1])
   );

   // Array writes; port B lands last when both write one location
   always @(posedge I_CLK) begin
      if (I_CE) begin
         if (acc[0] && wr[0] && loc[0] <= TOP_LOC) begin
            mem_reg[loc[0]] <= wword[0]; // [R02]
         end
         if (acc[1] && wr[1] && loc[1] <= TOP_LOC) begin
            mem_reg[loc[1]] <= wword[1]; // [R02] [R10]
         end
      end
   end

   // Identical read/driver logic per port
   genvar p;
   generate
      for (p = 0; p < 2; p = p + 1) begin : g_port
         always @(posedge I_CLK) begin
            if (I_RESET) begin
               word_reg[p] <= `DPSR_WORD_RESET;
               oe_reg[p]   <= 1'b0;
            end else if (I_CE) begin
               oe_reg[p] <= drv[p]; // [R08]
               if (acc[p]) begin
                  if (wr[p]) begin
                     word_reg[p] <= wword[p]; // [R09]
                  end else if (clash(acc[1-p], wr[1-p], loc[1-p], loc[p])) begin
                     word_reg[p] <= {`DPSR_BITS{1'bx}}; // [R15]
                  end else begin
                     word_reg[p] <= mem_reg[loc[p]]; // [R01] [R10]
                  end
               end
            end
         end
      end
   endgenerate

   assign O_PORT_A_READ_WORD    = word_reg[0];
   assign O_PORT_A_READ_WORD_OE = oe_reg[0];
   assign O_PORT_B_READ_WORD    = word_reg[1];
   assign O_PORT_B_READ_WORD_OE = oe_reg[1];

endmodule

// file: testbench/dpsr_port_model.sv
// Purpose: User logic driving one RAM port.
// Assumes: Runs on I_CLK; pins change only while the port clock is low.
// Notes:   Clock high five cycles, low eight between runs; word taken while high.
`timescale 1ns/1ps
module dpsr_port_model (
   input  wire        clk,
   input  wire        oe,
   input  wire [15:0] rd,
   output reg         pclk,
   output reg         sel_n,
   output reg         wr_n,
   output reg         drv_n,
   output reg  [7:0]  loc,
   output reg  [15:0] wd
);
   initial {pclk, sel_n, wr_n, drv_n, loc, wd} = {4'h7, 8'h00, 16'h0000};
   task run(input s, w, d, input [7:0] a, input [15:0] v, output [15:0] q, output e);
      begin
         @(posedge clk);
         {sel_n, wr_n, drv_n, loc, wd} <= {s, w, d, a, v};
         repeat (3) @(posedge clk);
         pclk <= 1'b1;
         repeat (5) @(posedge clk);
         q = rd;
         e = oe;
         pclk <= 1'b0;
         repeat (4) @(posedge clk);
         sel_n <= 1'b1;
         wd <= ~v;
      end
   endtask
endmodule

// file: testbench/dpsr_top_bench.sv
// Purpose: Self-checking bench for the dual-port RAM.
// Assumes: Two port models share I_CLK; clock enable held high.
// Notes:   Each scenario checks words; s_cross and s_standby also check driver enables.
`timescale 1ns/1ps
module dpsr_top_bench;
   reg         clk = 1'b0;
   reg         rst = 1'b1;
   integer     mismatches = 0;
   integer     compares = 0;
   reg  [15:0] q, p;
   reg         e, f;
   wire [15:0] ra, rb, aw, bw;
   wire [7:0]  al, bl;
   wire        ea, eb, ac, as_n, aw_n, ad_n, bc, bs_n, bw_n, bd_n;
   dpsr_port_model ma (.clk(clk), .oe(ea), .rd(ra), .pclk(ac), .sel_n(as_n),
      .wr_n(aw_n), .drv_n(ad_n), .loc(al), .wd(aw));
   dpsr_port_model mb (.clk(clk), .oe(eb), .rd(rb), .pclk(bc), .sel_n(bs_n),
      .wr_n(bw_n), .drv_n(bd_n), .loc(bl), .wd(bw));
   dpsr_top DUT (.I_CLK(clk), .I_RESET(rst), .I_CE(1'b1),
      .I_PORT_A_CLOCK(ac), .I_PORT_A_SELECT_N(as_n), .I_PORT_A_WRITE_N(aw_n),
      .I_PORT_A_DRIVE_N(ad_n), .I_PORT_A_LOCATION(al), .I_PORT_A_WRITE_WORD(aw),
      .I_PORT_B_CLOCK(bc), .I_PORT_B_SELECT_N(bs_n), .I_PORT_B_WRITE_N(bw_n),
      .I_PORT_B_DRIVE_N(bd_n), .I_PORT_B_LOCATION(bl), .I_PORT_B_WRITE_WORD(bw),
      .O_PORT_A_READ_WORD(ra), .O_PORT_A_READ_WORD_OE(ea),
      .O_PORT_B_READ_WORD(rb), .O_PORT_B_READ_WORD_OE(eb));
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD %0t got %h want %h", $time, seen, exp);
         end
      end
   endtask
   task wrap_up;
      begin
         if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task s_cross;
      begin
         fork
            ma.run(0, 0, 0, 8'h00, 16'hA5C3, q, e);
            mb.run(0, 0, 1, 8'hFF, 16'h3C5A, p, f);
         join
         chk(q, 16'hA5C3);
         chk({15'h0000, e}, 16'h0001);
         chk({15'h0000, f}, 16'h0000);
         fork
            ma.run(0, 1, 0, 8'hFF, 16'h0000, q, e);
            mb.run(0, 1, 0, 8'h00, 16'h0000, p, f);
         join
         chk(q, 16'h3C5A);
         chk(p, 16'hA5C3);
      end
   endtask
   task s_clash;
      begin
         fork
            ma.run(0, 1, 0, 8'h10, 16'h0000, q, e);
            mb.run(0, 0, 1, 8'h10, 16'h1234, p, f);
         join
         chk(q, 16'hXXXX);
         chk(p, 16'h1234);
      end
   endtask
   task s_standby;
      begin
         ma.run(1, 0, 0, 8'h00, 16'hFFFF, q, e);
         chk({15'h0000, e}, 16'h0000);
         chk(q, 16'h3C5A);
         mb.run(0, 1, 0, 8'h00, 16'h0000, p, f);
         chk(p, 16'hA5C3);
      end
   endtask
   initial forever #25 clk = ~clk;
   initial begin
      repeat (2000) @(posedge clk);
      mismatches = mismatches + 1;
      wrap_up;
   end
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      s_cross;
      s_standby;
      s_clash;
      wrap_up;
   end
endmodule

// file: testbench/dpsr_top_properties.sv
// Purpose: Port timing checks for the dual-port RAM.
// Assumes: Port pins stay stable while each port clock is high.
// Notes:   Outputs follow a pin clock rise by three I_CLK edges.
`timescale 1ns/1ps
module dpsr_top_checker (
   input wire        I_CLK, I_RESET, I_CE,
   input wire        I_PORT_A_CLOCK, I_PORT_A_SELECT_N, I_PORT_A_DRIVE_N,
   input wire        I_PORT_B_CLOCK, I_PORT_B_SELECT_N, I_PORT_B_DRIVE_N,
   input wire [15:0] O_PORT_A_READ_WORD, O_PORT_B_READ_WORD,
   input wire        O_PORT_A_READ_WORD_OE, O_PORT_B_READ_WORD_OE
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RESET || !I_CE);
   oe_rise_a: assert property ($rose(I_PORT_A_CLOCK) && !I_PORT_A_SELECT_N &&
      !I_PORT_A_DRIVE_N |-> ##3 O_PORT_A_READ_WORD_OE) else $error("A driver late");
   oe_rise_b: assert property ($rose(I_PORT_B_CLOCK) && !I_PORT_B_SELECT_N &&
      !I_PORT_B_DRIVE_N |-> ##3 O_PORT_B_READ_WORD_OE) else $error("B driver late");
   oe_idle_a: assert property (!I_PORT_A_CLOCK [*4] |-> !O_PORT_A_READ_WORD_OE)
      else $error("A drives with clock low");
   oe_idle_b: assert property (!I_PORT_B_CLOCK [*4] |-> !O_PORT_B_READ_WORD_OE)
      else $error("B drives with clock low");
   sel_off_a: assert property (I_PORT_A_SELECT_N [*4] |-> !O_PORT_A_READ_WORD_OE)
      else $error("A drives while deselected");
   sel_off_b: assert property (I_PORT_B_SELECT_N [*4] |-> !O_PORT_B_READ_WORD_OE)
      else $error("B drives while deselected");
   hold_high_a: assert property (I_PORT_A_CLOCK [*4] |=> $stable(O_PORT_A_READ_WORD))
      else $error("A word moved mid access");
   precharge_b: assert property (!I_PORT_B_CLOCK [*4] |=> $stable(O_PORT_B_READ_WORD))
      else $error("B word moved in precharge");
endmodule
bind dpsr_top dpsr_top_checker chk_i (.*);
